/* design/fault_guard_defines.svh */
// Purpose: Constants for the parity and fence violation logic.
// Assumes: 15-bit memory addresses, 16-bit data words.
// Notes: Included by the package, fence_compare, parity_fence_guard and the checker.
`ifndef FAULT_GUARD_DEFINES_SVH
`define FAULT_GUARD_DEFINES_SVH
`define ADDR_W 15
`define WORD_W 16
`define SOURCE_BIT 15
`define VIOLATION_IO_ADDR 6'h05
`define SWITCH_IO_ADDR 6'h01
`define PROTECT_LOW_ADDR 15'h0002
`define ACC_A_ADDR 15'h0000
`define ACC_B_ADDR 15'h0001
`define CAPTURE_RESET 16'h0000
`define FENCE_RESET 15'h0000
`define CLOCK_PERIOD_NS 25
`define CAPTURE_TIME_NS 196
`define CAPTURE_CYCLES ((`CAPTURE_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`endif

/* design/fault_guard_pkg.sv */
// Purpose: Types shared by the parity and fence violation logic.
// Assumes: Constants come from the defines header.
// Notes: Instruction classes are decoded by the processor control.
`include "fault_guard_defines.svh"
package fault_guard_pkg;
    typedef enum logic [2:0] {
        op_other = 3'b000,
        op_jump = 3'b001,
        op_subroutine_jump = 3'b010,
        op_increment_skip = 3'b011,
        op_store_a = 3'b100,
        op_store_b = 3'b101,
        op_double_store = 3'b110
    } mem_op_t;
    typedef enum logic [1:0] {
        cap_idle = 2'b00,
        cap_freeze = 2'b01,
        cap_latch = 2'b10
    } capture_state_t;
endpackage

/* design/fault_capture_if.sv */
// Purpose: Carries capture requests from the parity path to the main block.
// Assumes: Single clock domain.
// Notes: The requester holds the request until done pulses.
`timescale 1ns/10ps
interface fault_capture_if;
    logic request;
    logic done;
    logic freeze;
    modport requester (output request, input done, input freeze);
    modport capturer (input request, output done, output freeze);
endinterface // fault_capture_if

/* design/fence_compare.sv */
// Purpose: Fence arithmetic for checked instructions.
// Assumes: Operand address is held stable during execute.
// Notes: Purely combinational.
`timescale 1ns/10ps
`include "fault_guard_defines.svh"
module fence_compare (
    // Operands
    input wire logic [`ADDR_W-1:0] fence_i,
    input wire logic [`ADDR_W-1:0] operand_address_holding_i,
    input wire fault_guard_pkg::mem_op_t op_i,
    // Results
    output logic [`WORD_W-1:0] fence_compare_subtract_o,
    output logic below_low_o,
    output logic acc_target_o
);
    import fault_guard_pkg::*;
    logic [`WORD_W-1:0] diff;
    always_comb begin
        diff = {1'b0, fence_i} - {1'b0, operand_address_holding_i} - 16'h0001;
        fence_compare_subtract_o = diff;
        below_low_o = operand_address_holding_i < `PROTECT_LOW_ADDR;
        acc_target_o = (op_i == op_jump) && ((operand_address_holding_i == `ACC_A_ADDR) ||
            (operand_address_holding_i == `ACC_B_ADDR));
    end
endmodule // fence_compare

/* design/parity_request.sv */
// Purpose: Catches memory parity faults in interrupting mode while the processor is running.
// Assumes: Parity pulse arrives on the processor clock.
// Notes: Holds the request until the capture completes.
`timescale 1ns/10ps
module parity_request (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Fault input
    input wire logic fault_i,
    // Capture handshake
    fault_capture_if.requester cap
);
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cap.request <= 1'b0;
        end else if (fault_i) begin
            cap.request <= 1'b1;
        end else if (cap.done) begin
            cap.request <= 1'b0;
        end
    end
endmodule // parity_request

/* design/parity_fence_guard.sv */
// Purpose: Parity fault and fence violation detection with a shared violation register.
// Assumes: Processor control supplies decoded instruction strobes on the same clock.
// Notes: Mode switch is a pin from the panel, so it is synchronised.
`timescale 1ns/10ps
`include "fault_guard_defines.svh"
// Contract
// - Operator switch selects parity halting mode or interrupting mode.
// - Halting mode parity fault raises halt request to processor control.
// - Halting mode parity fault also drives panel parity indication.
// - Lamp holds until preset in halt mode; until acknowledge in interrupt mode.
// - Interrupting mode parity fault copies address bits 0-14 into violation register; the code copies only while running_i is high.
// - Parity address capture freezes the processor for exactly one 196 ns period; the code freezes for 8 clock periods (200 ns).
// - Parity capture sets top bit of violation register.
// - Parity interrupt loads I/O address 05 and requests interrupt.
// - Protection on blocks all I/O instructions except address 01.
// - Jump, subroutine jump, increment skip and stores into protected area interrupt.
// - Output from A or B to address 05 loads the fence register.
// - Protected region lower bound is address 00002.
// - With protection on, jump to addresses 00000 or 00001 is a violation.
// - Execute computes fence minus operand address minus one.
// - Bit 15 set or protection off skips; otherwise inhibit and interrupt.
// - Protection violation copies address bits and clears the source flag.
// - Protection interrupt loads I/O address 05 and requests interrupt.
module parity_fence_guard (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Operator controls
    input wire logic parity_interrupt_mode_i,
    input wire logic preset_i,
    // Memory section
    input wire logic parity_fault_i,
    input wire logic [`ADDR_W-1:0] memory_address_i,
    // Processor control
    input wire logic running_i,
    input wire logic protect_enable_i,
    input wire logic execute_check_i,
    input wire fault_guard_pkg::mem_op_t op_i,
    input wire logic [`ADDR_W-1:0] operand_address_holding_i,
    input wire logic io_instr_i,
    input wire logic [5:0] io_address_i,
    input wire logic output_from_accumulator_a_i,
    input wire logic output_from_accumulator_b_i,
    input wire logic [`WORD_W-1:0] io_data_i,
    input wire logic interrupt_ack_i,
    // Results to processor
    output logic halt_request_o,
    output logic parity_halt_indication_o,
    output logic freeze_o,
    output logic no_violation_skip_o,
    output logic inhibit_o,
    output logic io_blocked_o,
    output logic interrupt_request_o,
    output logic [5:0] central_interrupt_address_o,
    output logic [`WORD_W-1:0] fault_address_capture_o
);
    import fault_guard_pkg::*;

    localparam int CAPTURE_CYCLES = `CAPTURE_CYCLES;

    fault_capture_if cap ();
    logic [2:0] mode_sync;
    logic int_mode;
    logic [`ADDR_W-1:0] fence;
    logic [`WORD_W-1:0] diff;
    logic below_low;
    logic acc_target;
    logic checked_op;
    logic violation;
    logic parity_halt_event;
    logic parity_int_event;
    logic fault_source_flag;
    logic [`ADDR_W-1:0] captured_addr;
    logic [`ADDR_W-1:0] parity_addr;
    logic lamp;
    logic [7:0] freeze_count;
    capture_state_t cap_state;

    // Mode switch is a panel pin; a change counts once two stages agree.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_sync <= 3'h0;
            int_mode <= 1'b0;
        end else begin
            mode_sync <= {mode_sync[1:0], parity_interrupt_mode_i};
            if (mode_sync[2] == mode_sync[1]) begin
                int_mode <= mode_sync[1];
            end
        end
    end

    assign parity_halt_event = parity_fault_i && !int_mode;
    assign parity_int_event = parity_fault_i && int_mode && running_i;

    parity_request u_parity_request (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .fault_i(parity_int_event),
        .cap(cap.requester)
    );

    fence_compare u_fence_compare (
        .fence_i(fence),
        .operand_address_holding_i(operand_address_holding_i),
        .op_i(op_i),
        .fence_compare_subtract_o(diff),
        .below_low_o(below_low),
        .acc_target_o(acc_target)
    );

    assign checked_op = (op_i != op_other);
    // Addresses below the lower bound are never fenced, apart from the accumulator jump case.
    always_comb begin
        violation = 1'b0;
        if (execute_check_i && checked_op && protect_enable_i) begin
            violation = (!diff[`SOURCE_BIT] && !below_low) || acc_target;
        end
    end
    assign no_violation_skip_o = execute_check_i && checked_op && !violation;
    assign inhibit_o = violation;
    assign io_blocked_o = protect_enable_i && io_instr_i && (io_address_i != `SWITCH_IO_ADDR);

    // Fence load from either accumulator.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fence <= `FENCE_RESET;
        end else if ((output_from_accumulator_a_i || output_from_accumulator_b_i) &&
                     io_address_i == `VIOLATION_IO_ADDR && !io_blocked_o) begin
            fence <= io_data_i[`ADDR_W-1:0];
        end
    end

    // Parity capture sequencer: address sampled on the request, frozen for 8 clock periods, then copied to the violation register.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cap_state <= cap_idle;
            freeze_count <= 8'h00;
            parity_addr <= `FENCE_RESET;
        end else begin
            case (cap_state)
                cap_idle: begin
                    if (cap.request) begin
                        cap_state <= cap_freeze;
                        freeze_count <= 8'(CAPTURE_CYCLES - 1);
                        parity_addr <= memory_address_i;
                    end
                end
                cap_freeze: begin
                    if (freeze_count == 8'h00) begin
                        cap_state <= cap_latch;
                    end else begin
                        freeze_count <= freeze_count - 8'h01;
                    end
                end
                cap_latch: begin
                    cap_state <= cap_idle;
                end
                default: begin
                    cap_state <= cap_idle;
                end
            endcase
        end
    end
    assign cap.freeze = (cap_state == cap_freeze);
    assign cap.done = (cap_state == cap_latch);
    assign freeze_o = cap.freeze;

    // Violation register; a protection fault in the latch cycle wins as the newer event.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            captured_addr <= `FENCE_RESET;
            fault_source_flag <= 1'b0;
        end else if (violation) begin
            captured_addr <= memory_address_i;
            fault_source_flag <= 1'b0;
        end else if (cap.done) begin
            captured_addr <= parity_addr;
            fault_source_flag <= 1'b1;
        end
    end
    assign fault_address_capture_o = {fault_source_flag, captured_addr};

    // Interrupt request held until acknowledged; a new fault wins over the acknowledge.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            interrupt_request_o <= 1'b0;
            central_interrupt_address_o <= 6'h00;
        end else if (violation || cap.done) begin
            interrupt_request_o <= 1'b1;
            central_interrupt_address_o <= `VIOLATION_IO_ADDR;
        end else if (interrupt_ack_i) begin
            interrupt_request_o <= 1'b0;
        end
    end

    // Halt request and lamp; set wins over preset or acknowledge.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            halt_request_o <= 1'b0;
            lamp <= 1'b0;
        end else begin
            halt_request_o <= parity_halt_event;
            if (parity_fault_i) begin
                lamp <= 1'b1;
            end else if (!int_mode && preset_i) begin
                lamp <= 1'b0;
            end else if (int_mode && interrupt_ack_i) begin
                lamp <= 1'b0;
            end
        end
    end
    assign parity_halt_indication_o = lamp;
endmodule // parity_fence_guard

/* verification/parity_fence_guard_properties.sv */
// Purpose: Port-level checks of the parity and fence guard.
// Assumes: One clock domain; mode switch held for several cycles.
// Notes: Bound to the top module.
`timescale 1ns/10ps
`include "fault_guard_defines.svh"
module parity_fence_guard_checker (
    // Inputs watched
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic parity_interrupt_mode_i,
    input wire logic preset_i,
    input wire logic parity_fault_i,
    input wire logic [`ADDR_W-1:0] memory_address_i,
    input wire logic protect_enable_i,
    input wire logic execute_check_i,
    input wire logic io_instr_i,
    input wire logic [5:0] io_address_i,
    // Outputs watched
    input wire logic halt_request_o,
    input wire logic parity_halt_indication_o,
    input wire logic freeze_o,
    input wire logic no_violation_skip_o,
    input wire logic inhibit_o,
    input wire logic io_blocked_o,
    input wire logic interrupt_request_o,
    input wire logic [5:0] central_interrupt_address_o,
    input wire logic [`WORD_W-1:0] fault_address_capture_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // The mode switch is synchronised, so halting mode must have settled first.
    property p_halt;
        !parity_interrupt_mode_i [*5] ##0 parity_fault_i |=> halt_request_o;
    endproperty
    a_halt: assert property (p_halt) else $error("no halt request after parity fault");
    property p_lamp;
        !parity_interrupt_mode_i [*5] ##0 (parity_halt_indication_o && !preset_i) |=> parity_halt_indication_o;
    endproperty
    a_lamp: assert property (p_lamp) else $error("parity lamp dropped before preset");
    property p_skip;
        execute_check_i && !protect_enable_i |-> no_violation_skip_o && !inhibit_o;
    endproperty
    a_skip: assert property (p_skip) else $error("no skip with protection off");
    property p_cap_viol;
        inhibit_o |=> fault_address_capture_o == {1'b0, $past(memory_address_i)} && interrupt_request_o
            && central_interrupt_address_o == 6'h05;
    endproperty
    a_cap_viol: assert property (p_cap_viol) else $error("violation capture wrong");
    property p_freeze;
        $rose(freeze_o) |-> freeze_o [*8] ##1 !freeze_o;
    endproperty
    a_freeze: assert property (p_freeze) else $error("freeze length wrong");
    property p_cap_par;
        $fell(freeze_o) |-> ##[1:3] fault_address_capture_o[15] && interrupt_request_o
            && central_interrupt_address_o == 6'h05;
    endproperty
    a_cap_par: assert property (p_cap_par) else $error("parity capture wrong");
    property p_hold;
        !freeze_o [*4] ##0 !inhibit_o |=> $stable(fault_address_capture_o);
    endproperty
    a_hold: assert property (p_hold) else $error("capture changed without fault");
    property p_io;
        io_instr_i |-> io_blocked_o == (protect_enable_i && io_address_i != 6'h01);
    endproperty
    a_io: assert property (p_io) else $error("I/O blocking wrong");
endmodule // parity_fence_guard_checker
bind parity_fence_guard parity_fence_guard_checker chk (.clock_i, .rst_n_i, .parity_interrupt_mode_i, .preset_i,
    .parity_fault_i, .memory_address_i, .protect_enable_i, .execute_check_i, .io_instr_i, .io_address_i,
    .halt_request_o, .parity_halt_indication_o, .freeze_o, .no_violation_skip_o, .inhibit_o, .io_blocked_o,
    .interrupt_request_o, .central_interrupt_address_o, .fault_address_capture_o);

/* verification/proc_partner.sv */
// Purpose: Processor control side that acknowledges interrupts.
// Assumes: Acknowledge is a one-cycle pulse.
// Notes: Only acknowledges while the bench enables it.
`timescale 1ns/10ps
module proc_partner #(parameter int ACK_DELAY = 3) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Interrupt handshake
    input wire logic irq_i,
    input wire logic ack_en_i,
    output logic ack_o
);
    int wait_cnt;
    // A slow answer lets the bench see the request stand before it is taken.
    always @(negedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_cnt <= 0;
            ack_o <= 1'b0;
        end else begin
            ack_o <= irq_i && ack_en_i && !ack_o && wait_cnt >= ACK_DELAY;
            wait_cnt <= (irq_i && !ack_o) ? wait_cnt + 1 : 0;
        end
    end
endmodule // proc_partner

/* verification/parity_fence_guard_tb_top.sv */
// Purpose: Self-checking bench for the parity and fence guard.
// Assumes: Inputs change on the falling edge.
// Notes: Halt mode, fence protection and parity interrupt scenarios.
`timescale 1ns/10ps
module parity_fence_guard_tb_top;
    import fault_guard_pkg::*;
    logic clock_i, rst_n_i, parity_interrupt_mode_i, preset_i, parity_fault_i, running_i, protect_enable_i;
    logic execute_check_i, io_instr_i, output_from_accumulator_a_i, output_from_accumulator_b_i, interrupt_ack_i;
    logic halt_request_o, parity_halt_indication_o, freeze_o, no_violation_skip_o, inhibit_o, io_blocked_o;
    logic interrupt_request_o, ack_en;
    mem_op_t op_i;
    logic [14:0] memory_address_i, operand_address_holding_i;
    logic [5:0] io_address_i, central_interrupt_address_o;
    logic [15:0] io_data_i, fault_address_capture_o;
    int failures, n_checks, cycles, k;
    parity_fence_guard uut (.clock_i, .rst_n_i, .parity_interrupt_mode_i, .preset_i, .parity_fault_i,
        .memory_address_i, .running_i, .protect_enable_i, .execute_check_i, .op_i, .operand_address_holding_i,
        .io_instr_i, .io_address_i, .output_from_accumulator_a_i, .output_from_accumulator_b_i, .io_data_i,
        .interrupt_ack_i, .halt_request_o, .parity_halt_indication_o, .freeze_o, .no_violation_skip_o, .inhibit_o,
        .io_blocked_o, .interrupt_request_o, .central_interrupt_address_o, .fault_address_capture_o);
    proc_partner partner (.clock_i, .rst_n_i, .irq_i(interrupt_request_o), .ack_en_i(ack_en),
        .ack_o(interrupt_ack_i));
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bit_chk(input string what, input logic exp, input logic got);
        chk(what, {15'h0000, exp}, {15'h0000, got});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task automatic fence_wr(input logic use_a, input logic [15:0] v);
        io_instr_i = 1'b1;
        io_address_i = 6'h05;
        io_data_i = v;
        output_from_accumulator_a_i = use_a;
        output_from_accumulator_b_i = ~use_a;
        #1 bit_chk("blocked", protect_enable_i, io_blocked_o);
        cyc(1);
        output_from_accumulator_a_i = 1'b0;
        output_from_accumulator_b_i = 1'b0;
        io_address_i = 6'h01;
        #1 bit_chk("switch io", 1'b0, io_blocked_o);
        cyc(1);
        io_instr_i = 1'b0;
    endtask
    task automatic probe(input mem_op_t op, input logic [14:0] addr, input logic viol);
        execute_check_i = 1'b1;
        op_i = op;
        operand_address_holding_i = addr;
        memory_address_i = addr;
        #1 bit_chk("inhibit", viol, inhibit_o);
        bit_chk("skip", ~viol, no_violation_skip_o);
        cyc(1);
        execute_check_i = 1'b0;
        if (viol) begin
            chk("capture", {1'b0, addr}, fault_address_capture_o);
            chk("vector", 16'h0005, {10'h000, central_interrupt_address_o});
            bit_chk("irq", 1'b1, interrupt_request_o);
        end
        // An idle edge keeps back-to-back probes from dropping and raising the strobe in one step.
        cyc(1);
    endtask
    task automatic t_halt();
        cyc(5);
        parity_fault_i = 1'b1;
        cyc(1);
        parity_fault_i = 1'b0;
        bit_chk("halt", 1'b1, halt_request_o);
        bit_chk("lamp", 1'b1, parity_halt_indication_o);
        cyc(4);
        bit_chk("lamp held", 1'b1, parity_halt_indication_o);
        preset_i = 1'b1;
        cyc(1);
        preset_i = 1'b0;
        bit_chk("lamp preset", 1'b0, parity_halt_indication_o);
    endtask
    task automatic t_protect();
        fence_wr(1'b1, 16'h0040);
        protect_enable_i = 1'b1;
        probe(op_store_a, 15'h0050, 1'b0);
        probe(op_jump, 15'h0000, 1'b1);
        probe(op_store_a, 15'h0001, 1'b0);
        probe(op_store_b, 15'h003f, 1'b1);
        probe(op_double_store, 15'h0040, 1'b0);
        chk("hold", 16'h003f, fault_address_capture_o);
        protect_enable_i = 1'b0;
        fence_wr(1'b0, 16'h0100);
        protect_enable_i = 1'b1;
        for (int i = 1; i < 7; i++) begin
            probe(mem_op_t'(i), 15'(i) + 15'h00f8, 1'b1);
        end
        fence_wr(1'b1, 16'h0010);
        probe(op_increment_skip, 15'h0050, 1'b1);
        protect_enable_i = 1'b0;
        probe(op_jump, 15'h0000, 1'b0);
        ack_en <= 1'b1;
        cyc(8);
        bit_chk("irq acked", 1'b0, interrupt_request_o);
        ack_en <= 1'b0;
    endtask
    task automatic t_parity_int();
        parity_interrupt_mode_i = 1'b1;
        memory_address_i = 15'h1234;
        cyc(5);
        // A fault while the processor is halted must not start a capture.
        parity_fault_i = 1'b1;
        cyc(1);
        parity_fault_i = 1'b0;
        cyc(2);
        bit_chk("halted freeze", 1'b0, freeze_o);
        running_i = 1'b1;
        cyc(2);
        parity_fault_i = 1'b1;
        cyc(1);
        parity_fault_i = 1'b0;
        k = 0;
        repeat (13) begin
            k += freeze_o ? 1 : 0;
            cyc(1);
        end
        chk("freeze", 16'h0008, 16'(k));
        chk("capture", 16'h9234, fault_address_capture_o);
        chk("vector", 16'h0005, {10'h000, central_interrupt_address_o});
        bit_chk("lamp", 1'b1, parity_halt_indication_o);
        bit_chk("halt", 1'b0, halt_request_o);
        bit_chk("parity irq", 1'b1, interrupt_request_o);
        ack_en <= 1'b1;
        cyc(8);
        bit_chk("lamp acked", 1'b0, parity_halt_indication_o);
    endtask
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures++;
            tally_and_finish();
        end
    end
    initial begin
        {rst_n_i, parity_interrupt_mode_i, preset_i, parity_fault_i, running_i, protect_enable_i} = 6'h00;
        {execute_check_i, io_instr_i, output_from_accumulator_a_i, output_from_accumulator_b_i, ack_en} = 5'h00;
        op_i = op_other;
        {memory_address_i, operand_address_holding_i, io_address_i, io_data_i} = 52'h0;
        {failures, n_checks, cycles} = 96'h0;
        cyc(2);
        rst_n_i = 1'b1;
        t_halt();
        t_protect();
        t_parity_int();
        tally_and_finish();
    end
endmodule // parity_fence_guard_tb_top
